// ==== ppm_periph.sv ====
// Purpose: Behavioural peripheral on the far side of ppm_port
// Assumes: Status pins change just after clk_sys rising edges
// Notes:   slow stretches the busy answer
module ppm_periph (
  // Clock and control
  input  wire logic               clk_sys,
  input  wire ppm_pkg::ppm_mode_t mode,
  input  wire logic               slow,
  input  wire logic               intr,
  // Pins
  input  wire ppm_pkg::ppm_ctrl_t ctrl,
  input  wire logic [7:0]         pd_o,
  input  wire logic               pd_oe,
  output ppm_pkg::ppm_stat_t      stat_pin,
  output logic [7:0]              pd_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  logic       hi_q  = 1'b0;
  logic       put_q = 1'b0;
  wire        nib   = mode == ppm_pkg::PPM_MODE_NIBBLE;
  wire        ep    = mode == ppm_pkg::PPM_MODE_EPP;
  wire        ec    = mode == ppm_pkg::PPM_MODE_ECP;
  wire        act   = ep ? !(ctrl.autofd_n && ctrl.slctin_n) : !ctrl.strobe_n;
  wire [7:0]  nbyte = 8'h3C;
  wire [3:0]  half  = hi_q ? nbyte[7:4] : nbyte[3:0];
  // Host byte while driven, fixed peripheral bytes once released
  assign pd_i = pd_oe ? pd_o : (ec ? 8'h5A : 8'hC3);
  initial stat_pin = 5'h0B;
  // ==========================================================================
  // Handshakes
  always @(posedge clk_sys) begin
    if (nib) begin
      if (!ctrl.autofd_n && stat_pin.ack_n) begin
        {stat_pin.busy, stat_pin.pe, stat_pin.slct, stat_pin.error_n} <= half;
        put_q <= 1'b1;
        if (put_q) stat_pin.ack_n <= 1'b0;
      end else if (ctrl.autofd_n && !stat_pin.ack_n) begin
        stat_pin.ack_n <= 1'b1;
        put_q <= 1'b0;
        hi_q <= !hi_q;
      end
    end else begin
      hi_q <= 1'b0;
      put_q <= 1'b0;
      stat_pin.ack_n <= !(ep && intr);
      if (ec && !ctrl.init_n && !stat_pin.pe) stat_pin.ack_n <= ctrl.autofd_n;
      stat_pin.slct <= 1'b1;
      stat_pin.pe <= ec ? ctrl.init_n : 1'b0;
      stat_pin.error_n <= ec ? ctrl.init_n : 1'b1;
      if (act && !stat_pin.busy) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= (slow ? 4'h8 : 4'h1)) stat_pin.busy <= 1'b1;
      end else if (!act && stat_pin.busy) begin
        stat_pin.busy <= 1'b0;
        cnt_q <= 4'h0;
        if (mode == ppm_pkg::PPM_MODE_COMPAT) stat_pin.ack_n <= 1'b0;
      end
    end
  end
endmodule // ppm_periph

// ==== ppm_pkg.sv ====
// Purpose: Shared constants and carriers for the parallel port signalling block
// Assumes: 25 MHz system clock, one domain
// Notes:   Mode codes follow the extended control register mode field
package ppm_pkg;

  // ==========================================================================
  // Port modes
  typedef enum logic [2:0] {
    PPM_MODE_COMPAT = 3'b000,
    PPM_MODE_NIBBLE = 3'b001,
    PPM_MODE_FIFO   = 3'b010,
    PPM_MODE_ECP    = 3'b011,
    PPM_MODE_EPP    = 3'b100,
    PPM_MODE_RSV5   = 3'b101,
    PPM_MODE_TEST   = 3'b110,
    PPM_MODE_CFG    = 3'b111
  } ppm_mode_t;

  // ==========================================================================
  // Handshake sequencer states
  typedef enum logic [2:0] {
    PPM_ST_IDLE  = 3'b000,
    PPM_ST_SETUP = 3'b001,
    PPM_ST_STRB  = 3'b010,
    PPM_ST_WAIT  = 3'b011,
    PPM_ST_HOLD  = 3'b100,
    PPM_ST_DONE  = 3'b101
  } ppm_state_t;

  // ==========================================================================
  // Timing
  localparam int unsigned PPM_CLK_HZ      = 25_000_000;
  localparam int unsigned PPM_SETUP_NS    = 600;
  localparam int unsigned PPM_STRB_NS     = 600;
  localparam int unsigned PPM_EPP_GAP_NS  = 60;
  localparam int unsigned PPM_SETUP_CYC   = (PPM_SETUP_NS * (PPM_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PPM_STRB_CYC    = (PPM_STRB_NS * (PPM_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PPM_EPP_GAP_CYC = (PPM_EPP_GAP_NS * (PPM_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PPM_CNT_W       = 5;

  // ==========================================================================
  // Status line bit positions
  localparam int unsigned PPM_ST_BUSY = 3;
  localparam int unsigned PPM_ST_PE   = 2;
  localparam int unsigned PPM_ST_SLCT = 1;
  localparam int unsigned PPM_ST_ERRN = 0;

  // Control lines as driven on the pins (pin levels)
  typedef struct packed {
    logic strobe_n;
    logic autofd_n;
    logic slctin_n;
    logic init_n;
  } ppm_ctrl_t;

  // Status lines as seen on the pins
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic pe;
    logic slct;
    logic error_n;
  } ppm_stat_t;

  // Host side request
  typedef struct packed {
    logic       write;
    logic       addr;
    logic       cmd;
    logic [7:0] data;
  } ppm_req_t;

  localparam ppm_ctrl_t PPM_CTRL_IDLE = '{strobe_n: 1'b1, autofd_n: 1'b1, slctin_n: 1'b1, init_n: 1'b1};

endpackage : ppm_pkg

// ==== ppm_port.sv ====
// Purpose: Parallel port pin sequencer for compatibility, nibble, EPP and ECP modes
// Assumes: Mode comes from the extended control register; pins synchronised here
// Notes:
module ppm_port (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Configuration
  input  wire ppm_pkg::ppm_mode_t mode,
  input  wire logic              auto_lf,
  input  wire logic              select,
  input  wire logic              init_req,
  input  wire logic              rev_req,
  // Host requests
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire ppm_pkg::ppm_req_t req,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   rsp_cmd,
  output logic                   rsp_rev,
  // Events and status
  output logic                   irq,
  output logic                   rev_granted,
  output logic                   rev_pending,
  output ppm_pkg::ppm_stat_t     status,
  // Pins
  output ppm_pkg::ppm_ctrl_t     ctrl,
  output logic [7:0]             pd_o,
  output logic                   pd_oe,
  input  wire logic [7:0]        pd_i,
  input  wire ppm_pkg::ppm_stat_t stat_pin
);

  // ==========================================================================
  // Pin synchronisers
  ppm_pkg::ppm_stat_t stat_m_q, stat_s_q, stat_p_q;
  logic [7:0]         pd_m_q, pd_s_q;

  always_ff @(posedge clk_sys) begin
    stat_m_q <= stat_pin;
    stat_s_q <= stat_m_q;
    stat_p_q <= stat_s_q;
    pd_m_q   <= pd_i;
    pd_s_q   <= pd_m_q;
  end

  // ==========================================================================
  // Mode decode
  wire is_compat = (mode == ppm_pkg::PPM_MODE_COMPAT);
  wire is_nibble = (mode == ppm_pkg::PPM_MODE_NIBBLE);
  wire is_epp    = (mode == ppm_pkg::PPM_MODE_EPP);
  wire is_ecp    = (mode == ppm_pkg::PPM_MODE_ECP);
  wire busy_s    = stat_s_q.busy;
  wire ack_fall  = stat_p_q.ack_n & ~stat_s_q.ack_n;

  // ==========================================================================
  // Sequencer
  ppm_pkg::ppm_state_t state_q, state_d;
  logic [ppm_pkg::PPM_CNT_W-1:0] cnt_q, cnt_d;
  ppm_pkg::ppm_req_t req_q;
  logic [3:0] nib_lo_q;
  logic       nib_hi_q;
  logic       rev_q;

  function automatic logic [ppm_pkg::PPM_CNT_W-1:0] cyc(input int unsigned n);
    cyc = ppm_pkg::PPM_CNT_W'(n - 1);
  endfunction

  function automatic logic [3:0] nibble_of(input ppm_pkg::ppm_stat_t s);
    nibble_of = {s.busy, s.pe, s.slct, s.error_n};
  endfunction

  wire cnt_done  = (cnt_q == '0);
  wire nib_valid = ~stat_s_q.ack_n;
  wire rev_ok    = rev_q & ~stat_s_q.pe;
  wire rev_data  = rev_ok & ~stat_s_q.ack_n;

  assign req_ready = (state_q == ppm_pkg::PPM_ST_IDLE) & ~is_nibble & ~rev_q
                     & (is_compat | is_epp | is_ecp) & ~busy_s;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_done ? cnt_q : cnt_q - 1'b1;
    unique case (state_q)
      ppm_pkg::PPM_ST_IDLE: begin
        if (req_valid & req_ready) begin
          state_d = ppm_pkg::PPM_ST_SETUP;
          cnt_d   = cyc(is_epp ? ppm_pkg::PPM_EPP_GAP_CYC : ppm_pkg::PPM_SETUP_CYC);
        end else if (is_nibble & nib_valid) begin
          state_d = ppm_pkg::PPM_ST_HOLD;
        end else if (is_ecp & rev_data) begin
          state_d = ppm_pkg::PPM_ST_HOLD;
        end
      end
      ppm_pkg::PPM_ST_SETUP: begin
        if (cnt_done) begin
          state_d = ppm_pkg::PPM_ST_STRB;
          cnt_d   = cyc(ppm_pkg::PPM_STRB_CYC);
        end
      end
      ppm_pkg::PPM_ST_STRB: begin
        if (is_compat ? cnt_done : busy_s) begin
          state_d = ppm_pkg::PPM_ST_WAIT;
        end
      end
      ppm_pkg::PPM_ST_WAIT: begin
        if (is_compat | ~busy_s | is_epp) begin
          state_d = ppm_pkg::PPM_ST_DONE;
        end
      end
      ppm_pkg::PPM_ST_HOLD: begin
        if (stat_s_q.ack_n) begin
          state_d = ppm_pkg::PPM_ST_IDLE;
        end
      end
      ppm_pkg::PPM_ST_DONE: begin
        state_d = ppm_pkg::PPM_ST_IDLE;
      end
      default: state_d = ppm_pkg::PPM_ST_IDLE;
    endcase
    if (!(is_compat | is_nibble | is_epp | is_ecp)) begin
      state_d = ppm_pkg::PPM_ST_IDLE;
    end
  end

  wire nib_take = (state_q == ppm_pkg::PPM_ST_IDLE) & (state_d == ppm_pkg::PPM_ST_HOLD);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q  <= ppm_pkg::PPM_ST_IDLE;
      cnt_q    <= '0;
      req_q    <= '0;
      nib_lo_q <= 4'h0;
      nib_hi_q <= 1'b0;
      rev_q    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_cmd   <= 1'b0;
      rsp_rev   <= 1'b0;
      irq       <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      rev_q     <= is_ecp & rev_req;
      rsp_valid <= 1'b0;
      irq       <= is_epp & ack_fall;
      if ((state_q == ppm_pkg::PPM_ST_IDLE) & req_valid & req_ready) begin
        req_q <= req;
      end
      if (!is_nibble) begin
        nib_hi_q <= 1'b0;
      end else if (nib_take) begin
        nib_hi_q <= ~nib_hi_q;
        if (!nib_hi_q) begin
          nib_lo_q <= nibble_of(stat_s_q);
        end else begin
          rsp_valid <= 1'b1;
          rsp_data  <= {nibble_of(stat_s_q), nib_lo_q};
          rsp_cmd   <= 1'b0;
          rsp_rev   <= 1'b1;
        end
      end
      if (is_ecp & nib_take) begin
        rsp_valid <= 1'b1;
        rsp_data  <= pd_s_q;
        rsp_cmd   <= ~stat_s_q.busy;
        rsp_rev   <= 1'b1;
      end
      if (is_epp & ~req_q.write & (state_q == ppm_pkg::PPM_ST_WAIT)) begin
        rsp_valid <= 1'b1;
        rsp_data  <= pd_s_q;
        rsp_cmd   <= req_q.addr;
        rsp_rev   <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pin drive, one mode at a time
  wire busy_cycle = (state_q != ppm_pkg::PPM_ST_IDLE);
  wire strobing   = (state_q == ppm_pkg::PPM_ST_STRB) | (state_q == ppm_pkg::PPM_ST_WAIT);
  wire holding    = (state_q == ppm_pkg::PPM_ST_HOLD);

  always_comb begin
    ctrl = ppm_pkg::PPM_CTRL_IDLE;
    unique case (1'b1)
      is_compat: begin
        ctrl.strobe_n = ~(state_q == ppm_pkg::PPM_ST_STRB);
        ctrl.autofd_n = ~auto_lf;
        ctrl.slctin_n = ~select;
        ctrl.init_n   = ~init_req;
      end
      is_nibble: begin
        ctrl.autofd_n = holding;
        ctrl.slctin_n = 1'b1;
      end
      is_epp: begin
        ctrl.strobe_n = ~(busy_cycle & req_q.write);
        ctrl.autofd_n = ~(strobing & ~req_q.addr);
        ctrl.slctin_n = ~(strobing & req_q.addr);
        ctrl.init_n   = ~init_req;
      end
      is_ecp: begin
        ctrl.strobe_n = ~(state_q == ppm_pkg::PPM_ST_STRB);
        ctrl.autofd_n = rev_q ? holding : ~req_q.cmd;
        ctrl.slctin_n = 1'b1;
        ctrl.init_n   = ~rev_q;
      end
      default: ctrl = ppm_pkg::PPM_CTRL_IDLE;
    endcase
  end

  assign pd_oe       = (is_compat | is_ecp | is_epp) & ~rev_q
                       & ~(is_epp & busy_cycle & ~req_q.write);
  assign pd_o        = req_q.data;
  assign status      = stat_s_q;
  assign rev_granted = rev_ok;
  assign rev_pending = rev_data;

endmodule // ppm_port

// ==== ppm_port_chk.sv ====
// Purpose: Port-level assertions for ppm_port
// Assumes: One clk_sys domain, synchronous reset
// Notes:   Bound into every ppm_port instance
module ppm_port_chk (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               reset,
  // Host side
  input wire ppm_pkg::ppm_mode_t mode,
  input wire logic               rev_req,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire ppm_pkg::ppm_req_t  req,
  input wire logic               irq,
  input wire ppm_pkg::ppm_stat_t status,
  // Pins
  input wire ppm_pkg::ppm_ctrl_t ctrl,
  input wire logic               pd_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire cp  = mode == ppm_pkg::PPM_MODE_COMPAT;
  wire ep  = mode == ppm_pkg::PPM_MODE_EPP;
  wire ec  = mode == ppm_pkg::PPM_MODE_ECP;
  wire tk  = req_valid && req_ready;
  // ==========================================================================
  // Sequences and assertions
  sequence s_strb_fall; $fell(ctrl.strobe_n) && cp; endsequence
  sequence s_strb_15; ##14 !ctrl.strobe_n ##1 ctrl.strobe_n; endsequence
  a_strobe_data: assert property (cp && !ctrl.strobe_n |-> pd_oe) else $error("strobe without data");
  a_strobe_width: assert property (s_strb_fall |-> s_strb_15) else $error("strobe width");
  a_active_high: assert property ((ec || mode == ppm_pkg::PPM_MODE_NIBBLE)[*2] |-> ctrl.slctin_n) else $error("active");
  a_epp_write: assert property (ep && tk && req.write |=> !ctrl.strobe_n) else $error("write low");
  a_epp_read: assert property (ep && tk && !req.write |=> ctrl.strobe_n) else $error("read high");
  a_take_busy: assert property (tk |-> !status.busy) else $error("taken while busy");
  a_dstb_hold: assert property (ep && !ctrl.autofd_n && !status.busy ##1 ep |-> !ctrl.autofd_n) else $error("dstb");
  a_irq_pulse: assert property (irq |-> ep ##1 !irq) else $error("irq pulse");
  a_rev_init: assert property ((ec && rev_req)[*2] |-> !ctrl.init_n) else $error("reverse init");
  a_other_idle: assert property ((mode == ppm_pkg::PPM_MODE_TEST)[*2] |-> ctrl == ppm_pkg::PPM_CTRL_IDLE) else $error("idle");
endmodule // ppm_port_chk

bind ppm_port ppm_port_chk u_chk (.clk_sys, .reset, .mode, .rev_req, .req_valid, .req_ready, .req, .irq, .status,
  .ctrl, .pd_oe);

// ==== ppm_port_tb.sv ====
// Purpose: Self-checking bench for ppm_port
// Assumes: 25 MHz clk_sys, inputs driven at falling edges
// Notes:   Peripheral answers come from ppm_periph
module ppm_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 1'b0, reset = 1'b1, auto_lf = 1'b0, select = 1'b0, rev_req = 1'b0;
  logic               req_valid = 1'b0, slow = 1'b0, intr = 1'b0, irq_q = 1'b0;
  ppm_pkg::ppm_mode_t mode = ppm_pkg::PPM_MODE_COMPAT;
  ppm_pkg::ppm_req_t  req = '0;
  ppm_pkg::ppm_stat_t status, stat_pin;
  ppm_pkg::ppm_ctrl_t ctrl, low_q, cs_q;
  logic [7:0]         rsp_data, pd_o, pd_i, pd_q;
  logic               req_ready, rsp_valid, rsp_cmd, rsp_rev, irq, rev_granted, rev_pending, pd_oe;
  int                 bad_count = 0, n_tests = 0;
  initial forever #20 clk_sys = ~clk_sys;
  ppm_port u_dut (.clk_sys, .reset, .mode, .auto_lf, .select, .init_req(1'b0), .rev_req, .req_valid, .req_ready,
    .req, .rsp_valid, .rsp_data, .rsp_cmd, .rsp_rev, .irq, .rev_granted, .rev_pending, .status, .ctrl, .pd_o,
    .pd_oe, .pd_i, .stat_pin);
  ppm_periph u_per (.clk_sys, .mode, .slow, .intr, .ctrl, .pd_o, .pd_oe, .stat_pin, .pd_i);
  // ==========================================================================
  // Pin monitor and helpers
  always @(posedge clk_sys) begin
    low_q <= low_q | ~ctrl;
    if (!ctrl.strobe_n) pd_q <= pd_o;
    if (!ctrl.strobe_n) cs_q <= ctrl;
    if (irq) irq_q <= 1'b1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input ppm_pkg::ppm_mode_t m);
    @(negedge clk_sys);
    mode = m;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic xfer(input ppm_pkg::ppm_req_t r);
    int i;
    low_q = '0;
    req = r;
    req_valid = 1'b1;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    chk("ready to start", 8'h01, {7'h00, req_ready});
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    chk("ready after cycle", 8'h01, {7'h00, req_ready});
    repeat (3) @(negedge clk_sys);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_compat();
    go(ppm_pkg::PPM_MODE_COMPAT);
    auto_lf = 1'b1;
    select = 1'b1;
    xfer('{1'b1, 1'b0, 1'b0, 8'hA5});
    chk("compat data", 8'hA5, pd_q);
    chk("autofd", 8'h00, {7'h00, ctrl.autofd_n});
    chk("slctin", 8'h00, {7'h00, ctrl.slctin_n});
    chk("status", 8'h0B, {3'h0, status});
  endtask
  task automatic t_nibble();
    int i;
    go(ppm_pkg::PPM_MODE_NIBBLE);
    for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    chk("nibble byte", 8'h3C, rsp_data);
    chk("nibble tag", 8'h01, {6'h00, rsp_cmd, rsp_rev});
    chk("1284 active", 8'h01, {7'h00, ctrl.slctin_n});
  endtask
  task automatic t_epp();
    go(ppm_pkg::PPM_MODE_EPP);
    slow = 1'b1;
    xfer('{1'b1, 1'b0, 1'b0, 8'h5A});
    chk("epp write lines", 8'h0C, {4'h0, low_q});
    chk("epp data", 8'h5A, pd_q);
    xfer('{1'b0, 1'b1, 1'b0, 8'h00});
    chk("epp addr lines", 8'h02, {4'h0, low_q});
    chk("epp read", 8'hC3, rsp_data);
    chk("epp read tag", 8'h02, {6'h00, rsp_cmd, rsp_rev});
    irq_q = 1'b0;
    intr = 1'b1;
    repeat (3) @(negedge clk_sys);
    intr = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("epp irq", 8'h01, {7'h00, irq_q});
  endtask
  task automatic t_ecp();
    int i;
    go(ppm_pkg::PPM_MODE_ECP);
    slow = 1'b0;
    xfer('{1'b1, 1'b0, 1'b1, 8'h96});
    chk("ecp cmd", 8'h00, {7'h00, cs_q.autofd_n});
    chk("ecp byte", 8'h96, pd_q);
    xfer('{1'b1, 1'b0, 1'b0, 8'h69});
    chk("ecp data", 8'h01, {7'h00, cs_q.autofd_n});
    rev_req = 1'b1;
    for (i = 0; i < 200 && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    chk("reverse init", 8'h00, {7'h00, ctrl.init_n});
    chk("reverse grant", 8'h01, {7'h00, rev_granted});
    chk("reverse refuse", 8'h00, {7'h00, req_ready});
    chk("reverse pending", 8'h01, {7'h00, rev_pending});
    chk("reverse byte", 8'h5A, rsp_data);
    chk("reverse tag", 8'h03, {6'h00, rsp_cmd, rsp_rev});
    rev_req = 1'b0;
  endtask
  task automatic t_idle();
    go(ppm_pkg::PPM_MODE_TEST);
    chk("idle ctrl", 8'h0F, {4'h0, ctrl});
  endtask
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    t_compat();
    t_nibble();
    t_epp();
    t_ecp();
    t_idle();
    complete_run();
  end
endmodule // ppm_port_tb
